// ===== src/lfad_decoder.sv
// opcode decoder and execution timing for load, flag and add groups
`timescale 1ns/100ps
module lfad_decoder (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic protected_virtual_mode_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    output logic dec_valid_o,
    output lfad_pkg::lfad_insn_t insn_o,
    output logic insn_error_o,
    output logic exec_busy_o,
    output logic exec_done_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_OPC = 5'h01,
        ST_MODRM = 5'h02,
        ST_IMLO = 5'h04,
        ST_IMHI = 5'h08,
        ST_EXEC = 5'h10
    } lfad_state_t;

    lfad_state_t state_r, state_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [7:0] modrm_r, modrm_nxt;
    logic [15:0] imm_r, imm_nxt;
    logic [1:0] left_r, left_nxt;
    lfad_pkg::lfad_insn_t insn_r;
    lfad_pkg::lfad_insn_t insn_nxt;
    logic dec_valid_r, err_r;
    logic issue, err_nxt;
    logic timer_last;

    // ------------------------------------------------------------------
    // byte intake and field decode
    // ------------------------------------------------------------------
    wire take = byte_valid_i && byte_ready_o;
    wire in_exec = (state_r == ST_EXEC);
    wire lfad_pkg::lfad_op_t op_first = lfad_pkg::lfad_op_of(byte_i, 3'h0);
    wire first_modrm = lfad_pkg::lfad_has_modrm(byte_i);
    wire [1:0] first_imm = lfad_pkg::lfad_imm_bytes(byte_i);
    wire lfad_pkg::lfad_op_t op_full = lfad_pkg::lfad_op_of(opc_r,
                                                             byte_i[5:3]);
    wire [1:0] rm_imm = lfad_pkg::lfad_imm_bytes(opc_r);
    wire rm_is_reg = (byte_i[7:6] == lfad_pkg::MOD_REG);
    wire far_op_full = op_full == lfad_pkg::OP_LOAD_FAR_POINTER_DATA_SEG ||
                       op_full == lfad_pkg::OP_LOAD_FAR_POINTER_EXTRA_SEG;
    wire far_reg_form = far_op_full && rm_is_reg;
    wire sext_byte = opc_r[7:2] == lfad_pkg::PAT_IMM_GRP &&
                     opc_r[lfad_pkg::BIT_S] && opc_r[lfad_pkg::BIT_W];
    wire lfad_pkg::lfad_op_t op_nxt =
        lfad_pkg::lfad_op_of(opc_nxt, modrm_nxt[5:3]);
    wire mem_nxt = lfad_pkg::lfad_has_modrm(opc_nxt) &&
                   modrm_nxt[7:6] != lfad_pkg::MOD_REG;

    assign byte_ready_o = !in_exec;

    always_comb begin
        state_nxt = state_r;
        opc_nxt = opc_r;
        modrm_nxt = modrm_r;
        imm_nxt = imm_r;
        left_nxt = left_r;
        issue = 1'b0;
        err_nxt = 1'b0;
        unique case (state_r)
            ST_OPC: if (take) begin
                opc_nxt = byte_i;
                modrm_nxt = 8'h00;
                imm_nxt = 16'h0000;
                left_nxt = first_imm;
                if (first_modrm) state_nxt = ST_MODRM;
                else if (op_first == lfad_pkg::OP_NONE) err_nxt = 1'b1;
                else if (first_imm != 2'h0) state_nxt = ST_IMLO;
                else issue = 1'b1;
            end
            ST_MODRM: if (take) begin
                modrm_nxt = byte_i;
                if (op_full == lfad_pkg::OP_NONE || far_reg_form) begin
                    err_nxt = 1'b1;
                    state_nxt = ST_OPC;
                end else if (rm_imm != 2'h0) state_nxt = ST_IMLO;
                else issue = 1'b1;
            end
            ST_IMLO: if (take) begin
                imm_nxt = {sext_byte ? {8{byte_i[7]}} : 8'h00,
                           byte_i};
                if (left_r == 2'h2) state_nxt = ST_IMHI;
                else issue = 1'b1;
            end
            ST_IMHI: if (take) begin
                imm_nxt = {byte_i, imm_r[7:0]};
                issue = 1'b1;
            end
            ST_EXEC: if (timer_last) state_nxt = ST_OPC;
            default: state_nxt = ST_OPC;
        endcase
        if (issue) state_nxt = ST_EXEC;
    end

    // ------------------------------------------------------------------
    // decoded instruction word
    // ------------------------------------------------------------------
    always_comb begin
        insn_nxt.op = op_nxt;
        insn_nxt.w = opc_nxt[lfad_pkg::BIT_W];
        insn_nxt.d = opc_nxt[lfad_pkg::BIT_D];
        insn_nxt.s = opc_nxt[7:2] == lfad_pkg::PAT_IMM_GRP &&
                     opc_nxt[lfad_pkg::BIT_S];
        insn_nxt.mem = mem_nxt;
        insn_nxt.mode = modrm_nxt[7:6];
        insn_nxt.reg_f = (op_nxt == lfad_pkg::OP_INC_REG) ? opc_nxt[2:0]
                                                           : modrm_nxt[5:3];
        insn_nxt.rm = modrm_nxt[2:0];
        insn_nxt.imm = imm_nxt;
        insn_nxt.clocks = lfad_pkg::lfad_clocks(op_nxt, mem_nxt,
            protected_virtual_mode_i);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_OPC;
            opc_r <= 8'h00;
            modrm_r <= 8'h00;
            imm_r <= 16'h0000;
            left_r <= 2'h0;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
            opc_r <= opc_nxt;
            modrm_r <= modrm_nxt;
            imm_r <= imm_nxt;
            left_r <= left_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            insn_r <= '0;
            dec_valid_r <= 1'b0;
            err_r <= 1'b0;
        end else if (clk_en_i) begin
            if (issue) insn_r <= insn_nxt;
            dec_valid_r <= issue;
            err_r <= err_nxt;
        end
    end

    lfad_exec_timer #(
        .WIDTH(lfad_pkg::CNT_W)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .load_i(issue),
        .load_val_i(insn_nxt.clocks),
        .count_o(),
        .last_o(timer_last)
    );

    assign insn_o = insn_r;
    assign dec_valid_o = dec_valid_r;
    assign insn_error_o = err_r;
    assign exec_busy_o = in_exec;
    assign exec_done_o = in_exec && timer_last;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);

    wire is_op_offs = insn_r.op == lfad_pkg::OP_LOAD_EFFECTIVE_OFFSET;
    wire is_op_far = insn_r.op == lfad_pkg::OP_LOAD_FAR_POINTER_DATA_SEG ||
                     insn_r.op == lfad_pkg::OP_LOAD_FAR_POINTER_EXTRA_SEG;
    wire is_op_flag = insn_r.op == lfad_pkg::OP_FLAGS_TO_ACC_HIGH ||
                      insn_r.op == lfad_pkg::OP_ACC_HIGH_TO_FLAGS;

    offs_three_clk_a: assert property (
        dec_valid_o && is_op_offs |-> !exec_done_o ##1 !exec_done_o
        ##1 exec_done_o ##1 byte_ready_o)
        else $error("effective offset load not 3 clocks");
    far_real_time_a: assert property (
        dec_valid_o && is_op_far && !protected_virtual_mode_i
        && insn_r.clocks == lfad_pkg::CLK_FAR_REAL |-> ##6 exec_done_o)
        else $error("far pointer load not 7 clocks");
    far_prot_time_a: assert property (
        dec_valid_o && is_op_far && insn_r.clocks == lfad_pkg::CLK_FAR_PROT
        |-> exec_busy_o [*8] ##13 exec_done_o)
        else $error("far pointer load not 21 clocks");
    far_mem_only_a: assert property (
        dec_valid_o && is_op_far |-> insn_r.mode != lfad_pkg::MOD_REG)
        else $error("far pointer load issued with register form");
    far_reg_error_a: assert property (
        state_r == ST_MODRM && take && far_reg_form
        |=> insn_error_o && !exec_busy_o)
        else $error("register form far load not refused");
    flag_two_clk_a: assert property (
        dec_valid_o && is_op_flag |-> ##1 exec_done_o ##1 !exec_busy_o)
        else $error("flag byte transfer not 2 clocks");
    add_mem_time_a: assert property (
        dec_valid_o && insn_r.op == lfad_pkg::OP_ADD_RM && insn_r.mem
        |-> !exec_done_o [*6] ##1 exec_done_o)
        else $error("add with memory operand not 7 clocks");
    adc_acc_time_a: assert property (
        dec_valid_o && insn_r.op == lfad_pkg::OP_ADC_ACC
        |-> ##2 exec_done_o)
        else $error("add-with-carry accumulator form not 3 clocks");
    sign_ext_a: assert property (
        dec_valid_o && insn_r.s && insn_r.w
        |-> insn_r.imm[15:8] == {8{insn_r.imm[7]}})
        else $error("immediate byte not sign-extended");

    offs_seen_c: cover property (dec_valid_o && is_op_offs);
    far_prot_c: cover property (dec_valid_o && is_op_far &&
                                protected_virtual_mode_i);
    adc_imm_c: cover property (dec_valid_o &&
                               insn_r.op == lfad_pkg::OP_ADC_IMM);
    error_c: cover property (insn_error_o);
endmodule : lfad_decoder

// ===== src/lfad_exec_timer.sv
// down counter that times the execution phase of one instruction
`timescale 1ns/100ps
module lfad_exec_timer #(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_val_i,
    output logic [WIDTH-1:0] count_o,
    output logic last_o
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    assign count_nxt = load_i ? load_val_i :
                       (count_r != '0) ? count_r - 1'b1 : count_r;
    assign count_o = count_r;
    assign last_o = (count_r == {{(WIDTH-1){1'b0}}, 1'b1});

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) count_r <= '0;
        else if (clk_en_i) count_r <= count_nxt;
    end
endmodule : lfad_exec_timer

// ===== src/lfad_pkg.sv
// constants, types and decode functions for the load/flag/add decoder
package lfad_pkg;

    // ------------------------------------------------------------------
    // opcode encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_LOAD_EFFECTIVE_OFFSET = 8'h8d;
    localparam logic [7:0] OPC_LOAD_FAR_POINTER_DATA_SEG = 8'hc5;
    localparam logic [7:0] OPC_LOAD_FAR_POINTER_EXTRA_SEG = 8'hc4;
    localparam logic [7:0] OPC_FLAGS_TO_ACC_HIGH = 8'h9f;
    localparam logic [7:0] OPC_ACC_HIGH_TO_FLAGS = 8'h9e;
    localparam logic [7:0] OPC_FLAG_WORD_PUSH = 8'h9c;
    localparam logic [7:0] OPC_FLAG_WORD_POP = 8'h9d;
    localparam logic [5:0] PAT_ADD_RM = 6'h00;
    localparam logic [5:0] PAT_ADC_RM = 6'h04;
    localparam logic [5:0] PAT_SUB_RM = 6'h0a;
    localparam logic [5:0] PAT_IMM_GRP = 6'h20;
    localparam logic [6:0] PAT_ADD_ACC = 7'h02;
    localparam logic [6:0] PAT_ADC_ACC = 7'h0a;
    localparam logic [6:0] PAT_INC_RM = 7'h7f;
    localparam logic [4:0] PAT_INC_REG = 5'h08;
    localparam logic [2:0] REG_ADD = 3'h0;
    localparam logic [2:0] REG_ADC = 3'h2;
    localparam logic [2:0] REG_INC = 3'h0;
    localparam logic [1:0] MOD_REG = 2'h3;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_W = 0;
    localparam int BIT_D = 1;
    localparam int BIT_S = 1;

    // ------------------------------------------------------------------
    // execution clock counts
    // ------------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [4:0] CLK_OFFSET_LOAD = 5'h03;
    localparam logic [4:0] CLK_FAR_REAL = 5'h07;
    localparam logic [4:0] CLK_FAR_PROT = 5'h15;
    localparam logic [4:0] CLK_FLAG_XFER = 5'h02;
    localparam logic [4:0] CLK_FLAG_WORD_PUSH = 5'h03;
    localparam logic [4:0] CLK_FLAG_WORD_POP = 5'h05;
    localparam logic [4:0] CLK_RM_REG = 5'h02;
    localparam logic [4:0] CLK_RM_MEM = 5'h07;
    localparam logic [4:0] CLK_IMM_REG = 5'h03;
    localparam logic [4:0] CLK_IMM_MEM = 5'h07;
    localparam logic [4:0] CLK_ACC_IMM = 5'h03;
    localparam logic [4:0] CLK_INC_REG = 5'h02;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_LOAD_EFFECTIVE_OFFSET = 5'h01,
        OP_LOAD_FAR_POINTER_DATA_SEG = 5'h02,
        OP_LOAD_FAR_POINTER_EXTRA_SEG = 5'h03,
        OP_FLAGS_TO_ACC_HIGH = 5'h04,
        OP_ACC_HIGH_TO_FLAGS = 5'h05,
        OP_FLAG_WORD_PUSH = 5'h06,
        OP_FLAG_WORD_POP = 5'h07,
        OP_ADD_RM = 5'h08,
        OP_ADD_IMM = 5'h09,
        OP_ADD_ACC = 5'h0a,
        OP_ADC_RM = 5'h0b,
        OP_ADC_IMM = 5'h0c,
        OP_ADC_ACC = 5'h0d,
        OP_INC_RM = 5'h0e,
        OP_INC_REG = 5'h0f,
        OP_SUB_RM = 5'h10
    } lfad_op_t;

    typedef struct packed {
        lfad_op_t op;
        logic w;
        logic d;
        logic s;
        logic mem;
        logic [1:0] mode;
        logic [2:0] reg_f;
        logic [2:0] rm;
        logic [15:0] imm;
        logic [4:0] clocks;
    } lfad_insn_t;

    // ------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------
    function automatic lfad_op_t lfad_op_of(input logic [7:0] opc,
                                            input logic [2:0] rf);
        lfad_op_t op;
        op = OP_NONE;
        if (opc == OPC_LOAD_EFFECTIVE_OFFSET)
            op = OP_LOAD_EFFECTIVE_OFFSET;
        else if (opc == OPC_LOAD_FAR_POINTER_DATA_SEG)
            op = OP_LOAD_FAR_POINTER_DATA_SEG;
        else if (opc == OPC_LOAD_FAR_POINTER_EXTRA_SEG)
            op = OP_LOAD_FAR_POINTER_EXTRA_SEG;
        else if (opc == OPC_FLAGS_TO_ACC_HIGH) op = OP_FLAGS_TO_ACC_HIGH;
        else if (opc == OPC_ACC_HIGH_TO_FLAGS) op = OP_ACC_HIGH_TO_FLAGS;
        else if (opc == OPC_FLAG_WORD_PUSH) op = OP_FLAG_WORD_PUSH;
        else if (opc == OPC_FLAG_WORD_POP) op = OP_FLAG_WORD_POP;
        else if (opc[7:2] == PAT_ADD_RM) op = OP_ADD_RM;
        else if (opc[7:2] == PAT_ADC_RM) op = OP_ADC_RM;
        else if (opc[7:2] == PAT_SUB_RM) op = OP_SUB_RM;
        else if (opc[7:1] == PAT_ADD_ACC) op = OP_ADD_ACC;
        else if (opc[7:1] == PAT_ADC_ACC) op = OP_ADC_ACC;
        else if (opc[7:3] == PAT_INC_REG) op = OP_INC_REG;
        else if (opc[7:2] == PAT_IMM_GRP && rf == REG_ADD) op = OP_ADD_IMM;
        else if (opc[7:2] == PAT_IMM_GRP && rf == REG_ADC) op = OP_ADC_IMM;
        else if (opc[7:1] == PAT_INC_RM && rf == REG_INC) op = OP_INC_RM;
        return op;
    endfunction : lfad_op_of

    function automatic logic lfad_has_modrm(input logic [7:0] opc);
        return opc == OPC_LOAD_EFFECTIVE_OFFSET ||
               opc == OPC_LOAD_FAR_POINTER_DATA_SEG ||
               opc == OPC_LOAD_FAR_POINTER_EXTRA_SEG ||
               opc[7:2] == PAT_ADD_RM || opc[7:2] == PAT_ADC_RM ||
               opc[7:2] == PAT_SUB_RM || opc[7:2] == PAT_IMM_GRP ||
               opc[7:1] == PAT_INC_RM;
    endfunction : lfad_has_modrm

    function automatic logic [1:0] lfad_imm_bytes(input logic [7:0] opc);
        logic [1:0] n;
        n = 2'h0;
        if (opc[7:2] == PAT_IMM_GRP)
            n = (opc[BIT_S:BIT_W] == 2'h1) ? 2'h2 : 2'h1;
        else if (opc[7:1] == PAT_ADD_ACC || opc[7:1] == PAT_ADC_ACC)
            n = opc[BIT_W] ? 2'h2 : 2'h1;
        return n;
    endfunction : lfad_imm_bytes

    function automatic logic [4:0] lfad_clocks(input lfad_op_t op,
                                               input logic mem,
                                               input logic prot);
        logic [4:0] c;
        c = CLK_FLAG_XFER;
        case (op)
            OP_LOAD_EFFECTIVE_OFFSET: c = CLK_OFFSET_LOAD;
            OP_LOAD_FAR_POINTER_DATA_SEG, OP_LOAD_FAR_POINTER_EXTRA_SEG:
                c = prot ? CLK_FAR_PROT : CLK_FAR_REAL;
            OP_FLAG_WORD_PUSH: c = CLK_FLAG_WORD_PUSH;
            OP_FLAG_WORD_POP: c = CLK_FLAG_WORD_POP;
            OP_ADD_RM, OP_ADC_RM, OP_SUB_RM, OP_INC_RM:
                c = mem ? CLK_RM_MEM : CLK_RM_REG;
            OP_ADD_IMM, OP_ADC_IMM: c = mem ? CLK_IMM_MEM : CLK_IMM_REG;
            OP_ADD_ACC, OP_ADC_ACC: c = CLK_ACC_IMM;
            OP_INC_REG: c = CLK_INC_REG;
            default: c = CLK_FLAG_XFER;
        endcase
        return c;
    endfunction : lfad_clocks

endpackage : lfad_pkg

// ===== tb/lfad_decoder_tb.sv
// self-checking bench for the load, flag and add decoder
`timescale 1ns/100ps
module lfad_decoder_tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic prot = 1'b0;
    logic slow = 1'b0;
    logic jit = 1'b0;
    logic [7:0] byte_i;
    logic byte_valid_i, byte_ready_o, dec_valid_o, insn_error_o;
    logic exec_busy_o, exec_done_o;
    lfad_pkg::lfad_insn_t insn;
    logic [32:0] eq[$];
    logic [31:0] seed = 32'h00005fc3;
    logic [7:0] base [14] = '{8'h8d, 8'hc5, 8'hc4, 8'h9f, 8'h9e,
                              8'h00, 8'h10, 8'h80, 8'h04, 8'h14,
                              8'h9c, 8'h28, 8'h40, 8'hfe};
    logic [7:0] msk [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h03, 8'h03, 8'h03, 8'h01, 8'h01,
                             8'h01, 8'h03, 8'h07, 8'h01};
    int fail_count = 0;
    int n_compared = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    lfad_decoder dut (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .protected_virtual_mode_i(prot),
        .byte_i(byte_i),
        .byte_valid_i(byte_valid_i),
        .byte_ready_o(byte_ready_o),
        .dec_valid_o(dec_valid_o),
        .insn_o(insn),
        .insn_error_o(insn_error_o),
        .exec_busy_o(exec_busy_o),
        .exec_done_o(exec_done_o)
    );

    lfad_fetch_model fm (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .byte_ready_i(byte_ready_o),
        .slow_i(slow),
        .byte_o(byte_i),
        .byte_valid_o(byte_valid_i)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    always @(posedge ref_clk_i) begin
        #10;
        clk_en_i = jit ? (rnd() % 4 != 0) : 1'b1;
    end

    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t: %s seen %0h expected %0h", $time, what,
                     seen, exp);
        end
    endtask : chk

    function automatic void exp_of(input logic [7:0] o, m, input logic p,
                                   output lfad_pkg::lfad_op_t op,
                                   output logic [4:0] c, output int nm, ni,
                                   output logic err);
        logic mem;
        mem = m[7:6] != 2'h3;
        op = lfad_pkg::OP_NONE;
        c = 5'h00;
        nm = 1;
        ni = 0;
        err = 1'b0;
        casez (o)
            8'h8d: begin
                op = lfad_pkg::OP_LOAD_EFFECTIVE_OFFSET;
                c = 5'h03;
            end
            8'b1100010?: begin
                op = o[0] ? lfad_pkg::OP_LOAD_FAR_POINTER_DATA_SEG :
                            lfad_pkg::OP_LOAD_FAR_POINTER_EXTRA_SEG;
                c = p ? 5'h15 : 5'h07;
                err = !mem;
            end
            8'b1001111?: begin
                op = o[0] ? lfad_pkg::OP_FLAGS_TO_ACC_HIGH :
                            lfad_pkg::OP_ACC_HIGH_TO_FLAGS;
                c = 5'h02;
                nm = 0;
            end
            8'b000?00??: begin
                op = o[4] ? lfad_pkg::OP_ADC_RM : lfad_pkg::OP_ADD_RM;
                c = mem ? 5'h07 : 5'h02;
            end
            8'b100000??: begin
                op = m[5:3] == 3'h2 ? lfad_pkg::OP_ADC_IMM :
                                      lfad_pkg::OP_ADD_IMM;
                err = m[5:3] != 3'h0 && m[5:3] != 3'h2;
                ni = o[1:0] == 2'h1 ? 2 : 1;
                c = mem ? 5'h07 : 5'h03;
            end
            8'b000?010?: begin
                op = o[4] ? lfad_pkg::OP_ADC_ACC : lfad_pkg::OP_ADD_ACC;
                nm = 0;
                ni = o[0] ? 2 : 1;
                c = 5'h03;
            end
            8'b1001110?: begin
                op = o[0] ? lfad_pkg::OP_FLAG_WORD_POP :
                            lfad_pkg::OP_FLAG_WORD_PUSH;
                c = o[0] ? 5'h05 : 5'h03;
                nm = 0;
            end
            8'b001010??: begin
                op = lfad_pkg::OP_SUB_RM;
                c = mem ? 5'h07 : 5'h02;
            end
            8'b01000???: begin
                op = lfad_pkg::OP_INC_REG;
                c = 5'h02;
                nm = 0;
            end
            8'b1111111?: begin
                op = lfad_pkg::OP_INC_RM;
                err = m[5:3] != 3'h0;
                c = mem ? 5'h07 : 5'h02;
            end
            default: begin
                nm = 0;
                err = 1'b1;
            end
        endcase
    endfunction : exp_of

    task automatic issue(input logic [7:0] o, m, input logic [15:0] imm);
        lfad_pkg::lfad_op_t op;
        logic [4:0] c;
        int nm, ni;
        logic err;
        exp_of(o, m, prot, op, c, nm, ni, err);
        fm.push(o);
        if (nm > 0) fm.push(m);
        if (!err && ni > 0) fm.push(imm[7:0]);
        if (!err && ni > 1) fm.push(imm[15:8]);
        eq.push_back({prot, o, m, imm});
    endtask : issue

    task automatic check_next();
        logic [32:0] e;
        lfad_pkg::lfad_op_t op;
        logic [4:0] c;
        logic [15:0] xi;
        int nm, ni, k, n;
        logic err, en;
        e = eq.pop_front();
        exp_of(e[31:24], e[23:16], e[32], op, c, nm, ni, err);
        xi = ni == 2 ? e[15:0] : {8'h00, e[7:0]};
        if (e[31:26] == 6'h20 && e[25:24] == 2'h3) xi = {{8{e[7]}}, e[7:0]};
        k = 0;
        while (dec_valid_o !== 1'b1 && insn_error_o !== 1'b1 && k < 60) begin
            k++;
            @(negedge ref_clk_i);
        end
        chk(insn_error_o, err, "error flag");
        if (err) begin
            chk(byte_ready_o, 1'b1, "ready after error");
            do begin
                en = clk_en_i;
                @(negedge ref_clk_i);
            end while (en !== 1'b1);
            return;
        end
        chk(dec_valid_o, 1'b1, "issue");
        chk(insn.op, op, "op");
        chk(insn.clocks, c, "clock field");
        if (nm > 0) chk(insn.mem, e[23:22] != 2'h3, "mem");
        if (nm > 0) chk(insn.reg_f, e[21:19], "reg field");
        if (nm > 0) chk(insn.rm, e[18:16], "rm field");
        if (nm > 0) chk(insn.mode, e[23:22], "mode field");
        if (e[31:29] == 3'h0 || e[31:26] == 6'h20)
            chk(insn.w, e[24], "w bit");
        if (op inside {lfad_pkg::OP_ADD_RM, lfad_pkg::OP_ADC_RM})
            chk(insn.d, e[25], "d bit");
        if (op inside {lfad_pkg::OP_ADD_IMM, lfad_pkg::OP_ADC_IMM})
            chk(insn.s, e[25], "s bit");
        if (ni > 0) chk(insn.imm, xi, "immediate");
        n = 0;
        k = 0;
        while (exec_busy_o === 1'b1 && k < 60) begin
            if (clk_en_i === 1'b1) begin
                n++;
                chk(exec_done_o, n == c, "done");
            end
            k++;
            @(negedge ref_clk_i);
        end
        chk(n, c, "busy span");
    endtask : check_next

    task automatic drain();
        while (eq.size() > 0) check_next();
    endtask : drain

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] o, m;
        int j;
        repeat (2) @(posedge ref_clk_i);
        #10;
        resetn_i = 1'b1;
        @(negedge ref_clk_i);
        issue(8'h9f, 8'h00, 16'h0000);
        issue(8'h9e, 8'h00, 16'h0000);
        issue(8'h8d, 8'h46, 16'h0000);
        issue(8'h15, 8'h00, 16'h1234);
        issue(8'hc4, 8'hc0, 16'h0000);
        issue(8'hf4, 8'h00, 16'h0000);
        issue(8'h83, 8'h10, 16'h0080);
        issue(8'h80, 8'h08, 16'h0000);
        issue(8'h81, 8'hd0, 16'hbeef);
        issue(8'h02, 8'h06, 16'h0000);
        issue(8'hc5, 8'h46, 16'h0000);
        drain();
        @(posedge ref_clk_i);
        #10;
        prot = 1'b1;
        issue(8'hc5, 8'h46, 16'h0000);
        issue(8'hc4, 8'h06, 16'h0000);
        issue(8'h8d, 8'hc1, 16'h0000);
        drain();
        for (int b = 0; b < 8; b++) begin
            @(posedge ref_clk_i);
            #10;
            prot = b[0];
            slow = b[1];
            jit = b[2];
            for (int i = 0; i < 20; i++) begin
                r = rnd();
                j = r[7:0] % 14;
                o = base[j] | (r[15:8] & msk[j]);
                m = r[23:16];
                if (o[7:2] == 6'h20 && r[24]) m[5:3] = {1'b0, r[25], 1'b0};
                if (o[7:1] == 7'h7f && r[26]) m[5:3] = 3'h0;
                r = rnd();
                issue(o, m, r[15:0]);
            end
            drain();
        end
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        $display("FAIL at %0t: watchdog expired", $time);
        results();
    end
endmodule : lfad_decoder_tb

// ===== tb/lfad_fetch_model.sv
// prefetch queue model that offers instruction bytes to the decoder
`timescale 1ns/100ps
module lfad_fetch_model (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic byte_ready_i,
    input wire logic slow_i,
    output logic [7:0] byte_o,
    output logic byte_valid_o
);
    logic [7:0] q[$];
    logic taken;
    int gap;

    initial begin
        byte_o = 8'h00;
        byte_valid_o = 1'b0;
        taken = 1'b0;
        gap = 0;
    end

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push

    // byte held until taken; a stalled or empty queue shows a toggling bus
    always @(posedge ref_clk_i) begin
        taken = byte_valid_o && byte_ready_i && clk_en_i && resetn_i;
        #10;
        if (taken) begin
            void'(q.pop_front());
            gap = slow_i ? 2 : 0;
        end else if (gap > 0) begin
            gap--;
        end
        if (resetn_i && q.size() > 0 && gap == 0) begin
            byte_o = q[0];
            byte_valid_o = 1'b1;
        end else begin
            byte_o = ~byte_o;
            byte_valid_o = 1'b0;
        end
    end
endmodule : lfad_fetch_model
